//--- pd_partner_model.sv
// Protocol layer and port partner model for the soft-reset policy block.
// Assumes requests from the block are levels and every answer is a falling-edge pulse.
`timescale 1ns/10ps
`default_nettype none

module pd_partner_model (
	input wire logic clk_i,
	input wire logic prl_req_i,
	input wire logic tx_req_i,
	input wire logic [1:0] tx_msg_i,
	input wire logic [7:0] dly_i,
	input wire logic fail_i,
	input wire logic acc_en_i,
	output logic prl_done_o,
	output logic tx_done_o,
	output logic tx_err_o,
	output logic acc_o
);
	int cnt = 0;
	int acnt = -1;
	logic [1:0] kind = 2'h0;
	logic held = 1'b0;

	// A request is answered once only; a new kind of request rearms the answer.
	always @(negedge clk_i) begin
		{prl_done_o, tx_done_o, tx_err_o, acc_o} <= 4'h0;
		if ({prl_req_i, tx_req_i} != kind) begin
			cnt = 0;
			held = 1'b0;
		end
		kind = {prl_req_i, tx_req_i};
		if (kind != 2'h0 && !held) begin
			if (cnt == int'(dly_i)) begin
				held = 1'b1;
				prl_done_o <= prl_req_i;
				tx_err_o <= tx_req_i & fail_i;
				tx_done_o <= tx_req_i & ~fail_i;
				if (tx_req_i && !fail_i && tx_msg_i == 2'h1 && acc_en_i) begin
					acnt = 0;
				end
			end
			cnt++;
		end
		if (acnt >= 0) begin
			if (acnt == int'(dly_i) + 4) begin
				acc_o <= 1'b1;
				acnt = -1;
			end else begin
				acnt++;
			end
		end
	end
endmodule : pd_partner_model

`default_nettype wire

//--- pd_soft_reset_policy.sv
// Soft-reset and protocol-error policy for a power-delivery port, source or sink role.
// Assumes a protocol layer that reports errors, delivers messages and acknowledges requests.
`timescale 1ns/10ps
`default_nettype none
`include "pdsr_regs.svh"

module pd_soft_reset_policy
	import pdsr_pkg::*;
#(
	parameter int unsigned REPLY_WAIT_CYC = `PDSR_REPLY_WAIT_CYC
) (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic ROLE_IS_SOURCE_I,
	input wire logic ATTACHED_I,
	input wire logic ENGINE_READY_I,
	input wire logic CTX_OFFER_I,
	input wire logic CTX_CONTRACT_TRANSITION_I,
	input wire logic CTX_PR_SWAP_TRANSITION_I,
	input wire logic CTX_DR_SWAP_I,
	input wire logic DATA_ROLE_MISMATCH_I,
	input wire logic AMS_INTERRUPTIBLE_I,
	input wire logic FIRST_MSG_ACKED_I,
	input wire logic PRL_ERR_I,
	input wire logic TX_RETRY_FAIL_I,
	input wire logic RX_VALID_I,
	input wire logic RX_SOFT_RESET_I,
	input wire logic RX_ACCEPT_I,
	input wire logic RX_UNSUPPORTED_I,
	input wire logic PRL_RESET_DONE_I,
	input wire logic TX_DONE_I,
	input wire logic TX_ERR_I,
	output logic PRL_RESET_REQ_O,
	output logic TX_REQ_O,
	output logic [1:0] TX_MSG_O,
	output logic HARD_RESET_O,
	output logic ERROR_RECOVERY_O,
	output logic GOTO_OFFER_O,
	output logic GOTO_AWAIT_OFFER_O,
	output logic GOTO_DISCOVERY_O,
	output logic GOTO_IDLE_O,
	output logic REPLAY_MSG_O,
	output logic [2:0] STATE_O
);
	pe_state_e state_ff;
	pe_state_e nxt_state;
	logic hard_ff, nxt_hard;
	logic erec_ff, nxt_erec;
	logic offer_ff, nxt_offer;
	logic await_ff, nxt_await;
	logic disc_ff, nxt_disc;
	logic idle_ff, nxt_idle;
	logic replay_ff, nxt_replay;
	logic prl_rst_ff, nxt_prl_rst;
	logic tx_req_ff, nxt_tx_req;
	tx_msg_e tx_msg_ff, nxt_tx_msg;

	logic sr_rx, acc_rx, unsup_rx, err_any;
	logic case_disc, case_drs, case_benign;
	logic tmr_start, tmr_stop, tmr_run, tmr_exp;

	assign sr_rx = RX_VALID_I & RX_SOFT_RESET_I;
	assign acc_rx = RX_VALID_I & RX_ACCEPT_I;
	assign unsup_rx = RX_VALID_I & RX_UNSUPPORTED_I;
	assign err_any = PRL_ERR_I | TX_RETRY_FAIL_I;
	assign case_disc = ROLE_IS_SOURCE_I & CTX_OFFER_I & TX_RETRY_FAIL_I & ~ATTACHED_I;
	assign case_drs = CTX_DR_SWAP_I & DATA_ROLE_MISMATCH_I;
	assign case_benign = PRL_ERR_I & ~TX_RETRY_FAIL_I & (AMS_INTERRUPTIBLE_I | ~FIRST_MSG_ACKED_I);

	// Protocol layer requests are derived from the next state so they line up with it.
	assign nxt_prl_rst = (nxt_state == ST_SSR_PRL) | (nxt_state == ST_GSR_PRL);
	assign nxt_tx_req = (nxt_state == ST_SSR_TX) | (nxt_state == ST_GSR_TX) | (nxt_state == ST_NSUP_TX);
	assign nxt_tx_msg = (nxt_state == ST_SSR_TX) ? MSG_SOFT_RESET :
		(nxt_state == ST_GSR_TX) ? MSG_ACCEPT :
		(nxt_state == ST_NSUP_TX) ? MSG_NOT_SUPPORTED : MSG_NONE;

	// The timer is armed only once the soft reset message has really gone out.
	assign tmr_start = (state_ff == ST_SSR_TX) & (nxt_state == ST_SSR_WAIT);
	assign tmr_stop = (state_ff == ST_SSR_WAIT) & (nxt_state != ST_SSR_WAIT);

	always_comb begin
		nxt_state = state_ff;
		nxt_hard = 1'b0;
		nxt_erec = 1'b0;
		nxt_offer = 1'b0;
		nxt_await = 1'b0;
		nxt_disc = 1'b0;
		nxt_idle = 1'b0;
		nxt_replay = 1'b0;
		if (sr_rx) begin
			nxt_state = ST_GSR_PRL;
		end else begin
			unique case (state_ff)
				ST_WATCH: begin
					if (case_drs) begin
						nxt_erec = 1'b1;
					end else if (err_any) begin
						if (case_disc) begin
							nxt_disc = 1'b1;
						end else if (CTX_CONTRACT_TRANSITION_I) begin
							nxt_hard = 1'b1;
						end else if (CTX_PR_SWAP_TRANSITION_I) begin
							nxt_erec = ROLE_IS_SOURCE_I;
							nxt_hard = ~ROLE_IS_SOURCE_I;
						end else if (case_benign) begin
							nxt_idle = 1'b1;
							nxt_replay = 1'b1;
							if (unsup_rx) begin
								nxt_state = ST_NSUP_TX;
							end
						end else begin
							nxt_state = ST_SSR_PRL;
						end
					end else if (unsup_rx & ENGINE_READY_I) begin
						nxt_state = ST_NSUP_TX;
					end
				end
				ST_SSR_PRL: begin
					if (PRL_RESET_DONE_I) begin
						nxt_state = ST_SSR_TX;
					end
				end
				ST_SSR_TX: begin
					if (TX_ERR_I) begin
						nxt_hard = 1'b1;
						nxt_state = ST_WATCH;
					end else if (TX_DONE_I) begin
						nxt_state = ST_SSR_WAIT;
					end
				end
				ST_SSR_WAIT: begin
					if (acc_rx) begin
						nxt_offer = ROLE_IS_SOURCE_I;
						nxt_await = ~ROLE_IS_SOURCE_I;
						nxt_state = ST_WATCH;
					end else if (tmr_exp | TX_ERR_I) begin
						nxt_hard = 1'b1;
						nxt_state = ST_WATCH;
					end
				end
				ST_GSR_PRL: begin
					if (PRL_RESET_DONE_I) begin
						nxt_state = ST_GSR_TX;
					end
				end
				ST_GSR_TX: begin
					if (TX_ERR_I) begin
						nxt_hard = 1'b1;
						nxt_state = ST_WATCH;
					end else if (TX_DONE_I) begin
						nxt_offer = ROLE_IS_SOURCE_I;
						nxt_await = ~ROLE_IS_SOURCE_I;
						nxt_state = ST_WATCH;
					end
				end
				ST_NSUP_TX: begin
					// A not-supported reply that fails after retries falls back to soft reset.
					if (TX_ERR_I) begin
						nxt_state = ST_SSR_PRL;
					end else if (TX_DONE_I) begin
						nxt_state = ST_WATCH;
					end
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			state_ff <= ST_WATCH;
			{hard_ff, erec_ff, offer_ff, await_ff} <= 4'h0;
			{disc_ff, idle_ff, replay_ff} <= 3'h0;
			{prl_rst_ff, tx_req_ff} <= 2'h0;
			tx_msg_ff <= MSG_NONE;
		end else begin
			state_ff <= nxt_state;
			{hard_ff, erec_ff, offer_ff, await_ff} <= {nxt_hard, nxt_erec, nxt_offer, nxt_await};
			{disc_ff, idle_ff, replay_ff} <= {nxt_disc, nxt_idle, nxt_replay};
			{prl_rst_ff, tx_req_ff} <= {nxt_prl_rst, nxt_tx_req};
			tx_msg_ff <= nxt_tx_msg;
		end
	end

	reply_wait_timer #(
		.LOAD_CYC(REPLY_WAIT_CYC)
	) u_reply_wait_timer (
		.clk_i(SYS_CLK_I),
		.nrst_i(NRST_I),
		.start_i(tmr_start),
		.stop_i(tmr_stop),
		.running_o(tmr_run),
		.expired_o(tmr_exp)
	);

	assign PRL_RESET_REQ_O = prl_rst_ff;
	assign TX_REQ_O = tx_req_ff;
	assign TX_MSG_O = tx_msg_ff;
	assign HARD_RESET_O = hard_ff;
	assign ERROR_RECOVERY_O = erec_ff;
	assign GOTO_OFFER_O = offer_ff;
	assign GOTO_AWAIT_OFFER_O = await_ff;
	assign GOTO_DISCOVERY_O = disc_ff;
	assign GOTO_IDLE_O = idle_ff;
	assign REPLAY_MSG_O = replay_ff;
	assign STATE_O = state_ff;

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!NRST_I);

	logic in_watch;
	assign in_watch = (state_ff == ST_WATCH) & ~sr_rx;

	property p_plain_error;
		in_watch & PRL_ERR_I & ~TX_RETRY_FAIL_I & ~case_drs & ~CTX_CONTRACT_TRANSITION_I
			& ~CTX_PR_SWAP_TRANSITION_I & FIRST_MSG_ACKED_I & ~AMS_INTERRUPTIBLE_I
			|-> ##1 (state_ff == ST_SSR_PRL) && PRL_RESET_REQ_O && !TX_REQ_O;
	endproperty
	a_plain_error: assert property (p_plain_error)
		else $error("Plain protocol error did not start a soft reset.");

	property p_discovery;
		in_watch & ~case_drs & case_disc |-> ##1 GOTO_DISCOVERY_O && (state_ff == ST_WATCH);
	endproperty
	a_discovery: assert property (p_discovery)
		else $error("Unattached offer failure did not go to discovery.");

	property p_contract;
		in_watch & ~case_drs & err_any & ~case_disc & CTX_CONTRACT_TRANSITION_I
			|-> ##1 HARD_RESET_O && !PRL_RESET_REQ_O;
	endproperty
	a_contract: assert property (p_contract)
		else $error("Error during contract transition did not give hard reset.");

	property p_prswap;
		in_watch & ~case_drs & err_any & ~case_disc & ~CTX_CONTRACT_TRANSITION_I
			& CTX_PR_SWAP_TRANSITION_I
			|-> ##1 (ERROR_RECOVERY_O == $past(ROLE_IS_SOURCE_I)) && (HARD_RESET_O != ERROR_RECOVERY_O);
	endproperty
	a_prswap: assert property (p_prswap)
		else $error("Role swap error took the wrong recovery path.");

	property p_drswap;
		in_watch & case_drs |-> ##1 ERROR_RECOVERY_O ##1 !ERROR_RECOVERY_O;
	endproperty
	a_drswap: assert property (p_drswap)
		else $error("Data role mismatch did not trigger error recovery.");

	property p_benign;
		in_watch & ~case_drs & err_any & ~case_disc & ~CTX_CONTRACT_TRANSITION_I
			& ~CTX_PR_SWAP_TRANSITION_I & case_benign
			|-> ##1 GOTO_IDLE_O && REPLAY_MSG_O && !PRL_RESET_REQ_O;
	endproperty
	a_benign: assert property (p_benign)
		else $error("Interruptible error was not replayed in idle.");

	property p_ssr_sequence;
		(state_ff == ST_SSR_PRL) & PRL_RESET_DONE_I & ~sr_rx
			|-> ##1 TX_REQ_O && (TX_MSG_O == MSG_SOFT_RESET) && !tmr_run;
	endproperty
	a_ssr_sequence: assert property (p_ssr_sequence)
		else $error("Soft reset was not sent after the protocol layer reset.");

	property p_accept;
		(state_ff == ST_SSR_WAIT) & acc_rx & ~sr_rx
			|-> ##1 (GOTO_OFFER_O == $past(ROLE_IS_SOURCE_I)) && (GOTO_AWAIT_OFFER_O != GOTO_OFFER_O);
	endproperty
	a_accept: assert property (p_accept)
		else $error("Accept of soft reset took the wrong next state.");

	property p_timeout;
		(state_ff == ST_SSR_WAIT) & tmr_exp & ~acc_rx & ~sr_rx
			|-> ##1 HARD_RESET_O && (state_ff == ST_WATCH);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("Reply timer expiry did not give hard reset.");

	property p_got_sr;
		sr_rx |-> ##1 (state_ff == ST_GSR_PRL) && PRL_RESET_REQ_O && !TX_REQ_O;
	endproperty
	a_got_sr: assert property (p_got_sr)
		else $error("Received soft reset did not reset the protocol layer first.");

	property p_accept_sent;
		(state_ff == ST_GSR_TX) & TX_DONE_I & ~TX_ERR_I & ~sr_rx
			|-> ##1 (GOTO_OFFER_O == $past(ROLE_IS_SOURCE_I)) && (GOTO_AWAIT_OFFER_O != GOTO_OFFER_O) && !TX_REQ_O;
	endproperty
	a_accept_sent: assert property (p_accept_sent)
		else $error("Sent accept did not lead to offer or await offer.");

	property p_accept_err;
		(state_ff == ST_GSR_TX) & TX_ERR_I & ~sr_rx |-> ##1 HARD_RESET_O;
	endproperty
	a_accept_err: assert property (p_accept_err)
		else $error("Failed accept did not give hard reset.");

	property p_unsupported;
		in_watch & ~case_drs & ~err_any & unsup_rx & ENGINE_READY_I
			|-> ##1 TX_REQ_O && (TX_MSG_O == MSG_NOT_SUPPORTED);
	endproperty
	a_unsupported: assert property (p_unsupported)
		else $error("Unsupported message was not answered with not supported.");

	property p_timer_idle;
		(state_ff != ST_SSR_WAIT) |-> !tmr_run;
	endproperty
	a_timer_idle: assert property (p_timer_idle)
		else $error("Reply timer runs outside the soft reset wait.");

endmodule : pd_soft_reset_policy
`default_nettype wire

//--- pdsr_pkg.sv
// Types of the soft-reset and protocol-error policy block.
// Assumes nothing beyond a SystemVerilog compiler.
package pdsr_pkg;

	typedef enum logic [2:0] {
		ST_WATCH,
		ST_SSR_PRL,
		ST_SSR_TX,
		ST_SSR_WAIT,
		ST_GSR_PRL,
		ST_GSR_TX,
		ST_NSUP_TX
	} pe_state_e;

	typedef enum logic [1:0] {
		MSG_NONE,
		MSG_SOFT_RESET,
		MSG_ACCEPT,
		MSG_NOT_SUPPORTED
	} tx_msg_e;

endpackage : pdsr_pkg

//--- pdsr_regs.svh
// Constants of the soft-reset and protocol-error policy block.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef PDSR_REGS_SVH
`define PDSR_REGS_SVH

`define PDSR_CLK_PERIOD_NS 25
`define PDSR_REPLY_WAIT_MS 27
`define PDSR_REPLY_WAIT_CYC ((`PDSR_REPLY_WAIT_MS * 1000000) / `PDSR_CLK_PERIOD_NS)
`define PDSR_TIMER_W 21

`endif

//--- reply_wait_timer.sv
// Reply wait timer: a down counter with start, stop and a one-cycle expiry pulse.
// Assumes start and stop come from the policy state machine in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "pdsr_regs.svh"

module reply_wait_timer #(
	parameter int unsigned LOAD_CYC = `PDSR_REPLY_WAIT_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic stop_i,
	output logic running_o,
	output logic expired_o
);
	localparam int W = `PDSR_TIMER_W;
	localparam logic [W-1:0] LOAD = W'(LOAD_CYC);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;
	logic run_ff;
	logic nxt_run;
	logic exp_ff;
	logic nxt_exp;

	// A stop on the edge of expiry still suppresses the pulse, so a late timeout is never seen.
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		nxt_exp = 1'b0;
		if (start_i) begin
			nxt_cnt = LOAD;
			nxt_run = 1'b1;
		end else if (stop_i) begin
			nxt_run = 1'b0;
		end else if (run_ff) begin
			if (cnt_ff == W'(1)) begin
				nxt_run = 1'b0;
				nxt_exp = 1'b1;
			end else begin
				nxt_cnt = cnt_ff - W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
			exp_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
			exp_ff <= nxt_exp;
		end
	end

	assign running_o = run_ff;
	assign expired_o = exp_ff;

endmodule : reply_wait_timer
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the soft-reset and protocol-error policy block.
// Assumes the partner model answers every protocol layer request.
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import pdsr_pkg::*;
;
	localparam int RW = 20;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [8:0] ctx = 9'h000;
	logic [5:0] ev = 6'h00;
	logic [7:0] dly = 8'h00;
	logic fail = 1'b0;
	logic acc_en = 1'b0;
	wire logic prl_done, tx_done, tx_err, acc, prl_req, tx_req;
	wire logic [1:0] tx_msg;
	wire logic [6:0] dec;
	wire logic [2:0] st;
	int errors = 0;
	int comparisons = 0;

	always #12.5 clk = ~clk;

	pd_soft_reset_policy #(.REPLY_WAIT_CYC(RW)) u_pd_soft_reset_policy (
		.SYS_CLK_I(clk),
		.NRST_I(nrst),
		.ROLE_IS_SOURCE_I(ctx[8]),
		.ATTACHED_I(ctx[7]),
		.ENGINE_READY_I(ctx[6]),
		.CTX_OFFER_I(ctx[5]),
		.CTX_CONTRACT_TRANSITION_I(ctx[4]),
		.CTX_PR_SWAP_TRANSITION_I(ctx[3]),
		.CTX_DR_SWAP_I(ctx[2]),
		.DATA_ROLE_MISMATCH_I(ev[5]),
		.AMS_INTERRUPTIBLE_I(ctx[1]),
		.FIRST_MSG_ACKED_I(ctx[0]),
		.PRL_ERR_I(ev[4]),
		.TX_RETRY_FAIL_I(ev[3]),
		.RX_VALID_I(ev[2] | acc),
		.RX_SOFT_RESET_I(ev[1]),
		.RX_ACCEPT_I(acc),
		.RX_UNSUPPORTED_I(ev[0]),
		.PRL_RESET_DONE_I(prl_done),
		.TX_DONE_I(tx_done),
		.TX_ERR_I(tx_err),
		.PRL_RESET_REQ_O(prl_req),
		.TX_REQ_O(tx_req),
		.TX_MSG_O(tx_msg),
		.HARD_RESET_O(dec[6]),
		.ERROR_RECOVERY_O(dec[5]),
		.GOTO_OFFER_O(dec[4]),
		.GOTO_AWAIT_OFFER_O(dec[3]),
		.GOTO_DISCOVERY_O(dec[2]),
		.GOTO_IDLE_O(dec[1]),
		.REPLAY_MSG_O(dec[0]),
		.STATE_O(st)
	);

	pd_partner_model u_pd_partner_model (
		.clk_i(clk),
		.prl_req_i(prl_req),
		.tx_req_i(tx_req),
		.tx_msg_i(tx_msg),
		.dly_i(dly),
		.fail_i(fail),
		.acc_en_i(acc_en),
		.prl_done_o(prl_done),
		.tx_done_o(tx_done),
		.tx_err_o(tx_err),
		.acc_o(acc)
	);

	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic restart(input logic [8:0] c);
		ctx = c;
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
	endtask : restart

	// Events are one-cycle pulses, so the answer is judged exactly one cycle later.
	task automatic fire(input logic [5:0] e, input logic [6:0] xd, input logic [2:0] xs);
		ev = e;
		@(negedge clk);
		ev = 6'h00;
		check({1'b0, dec}, {1'b0, xd});
		check({5'h00, st}, {5'h00, xs});
	endtask : fire

	task automatic wait_st(input logic [2:0] s);
		int n;
		n = 0;
		while (st !== s) begin
			@(negedge clk);
			n++;
			if (n > 100) begin
				errors++;
				$display("BAD %0t state wait ran out", $time);
				report_and_stop();
			end
		end
	endtask : wait_st

	task automatic wait_dec(output int n);
		n = 0;
		while (dec === 7'h00) begin
			@(negedge clk);
			n++;
			if (n > 100) begin
				errors++;
				$display("BAD %0t decision wait ran out", $time);
				report_and_stop();
			end
		end
	endtask : wait_dec

	// A stray hard reset after the wait is left would show up here.
	task automatic no_late_hard;
		int n;
		n = 0;
		repeat (2 * RW) begin
			@(negedge clk);
			if (dec[6] !== 1'b0) n++;
		end
		check(8'(n), 8'h00);
	endtask : no_late_hard

	task automatic t_exceptions;
		logic [8:0] c [8] = '{9'h181, 9'h121, 9'h191, 9'h189, 9'h089, 9'h185, 9'h183, 9'h080};
		logic [5:0] e [8] = '{6'h08, 6'h08, 6'h10, 6'h10, 6'h10, 6'h20, 6'h14, 6'h14};
		logic [6:0] d [8] = '{7'h00, 7'h04, 7'h40, 7'h20, 7'h40, 7'h20, 7'h03, 7'h03};
		for (int i = 0; i < 8; i++) begin
			restart(c[i]);
			fire(e[i], d[i], (i == 0) ? 3'h1 : 3'h0);
		end
		$display("test exceptions done");
	endtask : t_exceptions

	task automatic t_send_sr(input logic role, input logic a, input logic f);
		int n;
		restart({role, 8'h81});
		acc_en = a;
		fail = f;
		fire(6'h10, 7'h00, 3'h1);
		check({7'h00, prl_req}, 8'h01);
		wait_st(3'h2);
		check({5'h00, tx_req, tx_msg}, 8'h05);
		if (!f) wait_st(3'h3);
		wait_dec(n);
		if (f) begin
			check({1'b0, dec}, 8'h40);
		end else if (a) begin
			check({1'b0, dec}, role ? 8'h10 : 8'h08);
			no_late_hard();
		end else begin
			check({1'b0, dec}, 8'h40);
			check({7'h00, n >= RW + 1 && n <= RW + 2}, 8'h01);
		end
		$display("test send soft reset done");
	endtask : t_send_sr

	task automatic t_got_sr(input logic role, input logic f);
		int n;
		restart({role, 8'h81});
		acc_en = 1'b0;
		fail = 1'b0;
		fire(6'h10, 7'h00, 3'h1);
		wait_st(3'h3);
		fail = f;
		fire(6'h06, 7'h00, 3'h4);
		check({7'h00, prl_req}, 8'h01);
		wait_st(3'h5);
		check({5'h00, tx_req, tx_msg}, 8'h06);
		wait_dec(n);
		check({1'b0, dec}, f ? 8'h40 : (role ? 8'h10 : 8'h08));
		no_late_hard();
		$display("test got soft reset done");
	endtask : t_got_sr

	task automatic t_nsup;
		restart(9'h0C1);
		fail = 1'b0;
		fire(6'h05, 7'h00, 3'h6);
		check({5'h00, tx_req, tx_msg}, 8'h07);
		wait_st(3'h0);
		ctx = 9'h081;
		fire(6'h05, 7'h00, 3'h0);
		// A clock edge passes so the event lines are not driven twice in one step.
		@(negedge clk);
		ctx = 9'h0C3;
		fire(6'h15, 7'h03, 3'h6);
		wait_st(3'h0);
		// A not-supported reply that fails must fall back to sending a soft reset.
		fail = 1'b1;
		fire(6'h05, 7'h00, 3'h6);
		wait_st(3'h1);
		check({7'h00, prl_req}, 8'h01);
		fail = 1'b0;
		$display("test not supported done");
	endtask : t_nsup

	initial begin
		restart(9'h081);
		t_exceptions();
		for (int r = 0; r < 2; r++) begin
			dly = (r == 1) ? 8'h03 : 8'h00;
			t_send_sr(r[0], 1'b1, 1'b0);
			t_send_sr(r[0], 1'b0, 1'b0);
			t_send_sr(r[0], 1'b0, 1'b1);
			t_got_sr(r[0], 1'b0);
			t_got_sr(r[0], 1'b1);
		end
		t_nsup();
		report_and_stop();
	end
endmodule : tb_top

`default_nettype wire
